/* include/aea_params.svh */
// Constants for the active energy accumulator
// Functional notes
// - Power samples add into a 49-bit signed accumulator; top 24 bits readable.
// - One sample is accumulated every five clock periods.
// - With both mode bits clear, accumulation is signed.
// - With both mode bits set, positive-only mode applies.
// - Positive-only mode ignores all negative samples.
// - Absolute mode accumulates magnitude, still skipping samples below no-load level.
// - Sign change and no-load detection keep running in every mode.
// - Samples are divided by the 8-bit divider; zero divides by one.
// - Reading the read-clear register returns energy, then clears the top 24 bits.
// - Active power goes to the waveform output at a selectable sample rate.
// - Energy wraps from largest positive to most negative and back.
// - Half-full events raise the interrupt when enabled; the overflow flag never sets, as the top 24 bits move by at most one per sample.
// - An active-low pulse output follows gain-calibrated power and mode.
// - After reset accumulation is signed, both mode bits off.
// - Line-cycle mode accumulates over programmed half cycles, aligned to zero crossings.
// - The half-cycle count register is 16 bits wide.
// - Period end sets the cycle-done flag; interrupt pends until it is cleared.
// - A new period starts at once; line energy is overwritten each end.
// - Writing the count clears line energy and restarts at next zero crossing.
// - Line energy uses the main path and the same bit weight.
// - Samples below the no-load threshold are not accumulated; zero disables.
// - Power is scaled by one plus signed 12-bit gain over 4096.
`ifndef AEA_PARAMS_SVH
`define AEA_PARAMS_SVH
`define AEA_OFS_WAVSEL 8'h0d
`define AEA_OFS_ACCCFG 8'h0f
`define AEA_OFS_NLCFG 8'h0e
`define AEA_OFS_IRQEN3 8'hdb
`define AEA_OFS_IRQST3 8'hde
`define AEA_OFS_ENERGY 8'h40
`define AEA_OFS_ENRC 8'h41
`define AEA_OFS_DIV 8'h42
`define AEA_OFS_HCYC 8'h43
`define AEA_OFS_LENERGY 8'h44
`define AEA_OFS_GAIN 8'h45
`define AEA_OFS_IRQST_LO 8'hdc
`define AEA_BIT_POS 0
`define AEA_BIT_ABS 1
`define AEA_BIT_SIGNDIR 2
`define AEA_BIT_CYCDONE 2
`define AEA_BIT_HALF 0
`define AEA_BIT_OVF 1
`define AEA_BIT_WAVEFORM_SAMPLE_ENABLE 5
`define AEA_BIT_NOLOAD 0
`define AEA_BIT_SIGN 1
`define AEA_SAMPLE_DIV 3'h4
`define AEA_GAIN_SHIFT 12
`define AEA_NL_LVL1 24'h000028
`define AEA_NL_LVL2 24'h000014
`define AEA_NL_LVL3 24'h00000a
`define AEA_PULSE_LOW 8'h10
`endif

/* include/aea_pkg.sv */
// Types for the active energy accumulator
package aea_pkg;
  typedef enum logic [2:0] {
    AEA_LC_IDLE = 3'b001,
    AEA_LC_WAIT = 3'b010,
    AEA_LC_RUN = 3'b100
  } aea_lc_e;
endpackage : aea_pkg

/* rtl/aea_active_energy.sv */
// Active energy accumulator with line-cycle mode and pulse output
`timescale 1ns/100ps
`include "aea_params.svh"
module aea_active_energy #(
  parameter int PW = 24,
  parameter int AW = 49,
  parameter int PULSE_BIT = 30
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Signal path
  input wire logic signed [PW-1:0] powerIn,
  input wire logic voltSign,
  // Register port
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regAddr,
  input wire logic [23:0] regWdata,
  output logic [23:0] regRdata_r,
  // Outputs
  output logic energyPulseOut_n_r,
  output logic irqOut_r,
  output logic wavValid_r,
  output logic signed [PW-1:0] wavData_r
);
  logic [7:0] waveformSourceSelect_r;
  logic [7:0] accumulationConfig_r;
  logic [7:0] noloadConfig_r;
  logic [7:0] irqEnableThree_r;
  logic [7:0] irqStatusThree_r;
  logic [7:0] irqStatusLow_r;
  logic [7:0] energyDivider_r;
  logic [15:0] halfCycleCount_r;
  logic [11:0] powerGain_r;
  logic signed [AW-1:0] acc_r;
  logic signed [AW-1:0] lineAcc_r;
  logic signed [23:0] lineCycleEnergy_r;
  logic [2:0] sampleCnt_r;
  logic [2:0] vSync_r;
  logic vStable_r;
  logic sampleTick;
  logic signed [PW+12:0] gained;
  logic signed [PW-1:0] scaled;
  logic signed [PW-1:0] divided;
  logic signed [PW-1:0] addend;
  logic [PW-1:0] mag;
  logic [23:0] nlLevel;
  logic belowNl;
  logic signed [AW-1:0] accNxt;
  logic [23:0] topOld;
  logic [23:0] topNew;
  logic evHalf;
  logic evOvf;
  logic zeroCross;
  logic crossPend_r;
  logic crossAtTick;
  logic cycleEnd;
  logic prevNeg_r;
  logic [15:0] halfCnt_r;
  logic [PULSE_BIT:0] pulseAcc_r;
  logic [7:0] pulseLow_r;
  logic [9:0] wavCnt_r;
  aea_pkg::aea_lc_e lcState_r;

  // Gain, divide, mode selection
  always_comb begin
    // Gain factor is 4096 plus the signed gain, kept 14 bits wide so 4096 stays positive
    gained = $signed(powerIn) * (14'sh1000 + $signed({{2{powerGain_r[11]}}, powerGain_r}));
    scaled = gained[PW+11:`AEA_GAIN_SHIFT];
    divided = (energyDivider_r == 8'h00) ? scaled : PW'(scaled / $signed({1'b0, energyDivider_r}));
    mag = scaled[PW-1] ? PW'(-scaled) : PW'(scaled);
    case (noloadConfig_r[1:0])
      2'h1: nlLevel = `AEA_NL_LVL1;
      2'h2: nlLevel = `AEA_NL_LVL2;
      2'h3: nlLevel = `AEA_NL_LVL3;
      default: nlLevel = 24'h000000;
    endcase
    belowNl = (noloadConfig_r[1:0] != 2'h0) && (24'(mag) < nlLevel);
    if (belowNl) begin
      addend = '0;
    end else if (accumulationConfig_r[`AEA_BIT_POS]) begin
      addend = divided[PW-1] ? PW'(0) : divided;
    end else if (accumulationConfig_r[`AEA_BIT_ABS]) begin
      addend = divided[PW-1] ? PW'(-divided) : divided;
    end else begin
      addend = divided;
    end
  end

  assign sampleTick = (sampleCnt_r == `AEA_SAMPLE_DIV);
  assign accNxt = acc_r + AW'(addend);
  assign topOld = acc_r[AW-1:AW-24];
  assign topNew = accNxt[AW-1:AW-24];
  assign evOvf = sampleTick && (topOld[23] != topNew[23]) && (topOld[22] == topNew[22]);
  assign evHalf = sampleTick && (topOld[22] != topNew[22]) && (topOld[23] == topNew[23]);
  assign zeroCross = (vSync_r[2] == vSync_r[1]) && (vSync_r[2] != vStable_r);
  assign crossAtTick = sampleTick && (zeroCross || crossPend_r);
  assign cycleEnd = (lcState_r == aea_pkg::AEA_LC_RUN) && crossAtTick
                    ? (halfCnt_r + 16'h0001 >= halfCycleCount_r) : 1'b0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sampleCnt_r <= 3'h0;
    end else begin
      sampleCnt_r <= sampleTick ? 3'h0 : sampleCnt_r + 3'h1;
    end
  end

  // Voltage sign sync; second and third stages decide
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vSync_r <= 3'h0;
      vStable_r <= 1'b0;
    end else begin
      vSync_r <= {vSync_r[1:0], voltSign};
      if (vSync_r[2] == vSync_r[1]) begin
        vStable_r <= vSync_r[2];
      end
    end
  end

  // A crossing lasts one clock; hold it until the next sample tick so none is lost
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crossPend_r <= 1'b0;
    end else if (sampleTick) begin
      crossPend_r <= 1'b0;
    end else if (zeroCross) begin
      crossPend_r <= 1'b1;
    end
  end

  // Main accumulator; read-clear wipes the top 24 bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_r <= '0;
    end else if (regRd && regAddr == `AEA_OFS_ENRC) begin
      acc_r <= {24'h000000, (sampleTick ? accNxt[AW-25:0] : acc_r[AW-25:0])};
    end else if (sampleTick) begin
      acc_r <= accNxt;
    end
  end

  // Line-cycle sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lcState_r <= aea_pkg::AEA_LC_IDLE;
      halfCnt_r <= 16'h0000;
      lineAcc_r <= '0;
      lineCycleEnergy_r <= 24'h000000;
    end else if (regWr && regAddr == `AEA_OFS_HCYC) begin
      lcState_r <= aea_pkg::AEA_LC_WAIT;
      halfCnt_r <= 16'h0000;
      lineAcc_r <= '0;
      lineCycleEnergy_r <= 24'h000000;
    end else begin
      case (lcState_r)
        aea_pkg::AEA_LC_IDLE: begin
          lcState_r <= aea_pkg::AEA_LC_WAIT;
        end
        aea_pkg::AEA_LC_WAIT: begin
          // Held until a crossing on a sample tick so no count is split
          if (crossAtTick) begin
            lcState_r <= aea_pkg::AEA_LC_RUN;
            lineAcc_r <= '0;
            halfCnt_r <= 16'h0000;
          end
        end
        aea_pkg::AEA_LC_RUN: begin
          if (cycleEnd) begin
            lineCycleEnergy_r <= lineAcc_r[AW-1:AW-24];
            lineAcc_r <= AW'(addend);
            halfCnt_r <= 16'h0000;
          end else if (sampleTick) begin
            lineAcc_r <= lineAcc_r + AW'(addend);
            if (crossAtTick) begin
              halfCnt_r <= halfCnt_r + 16'h0001;
            end
          end
        end
        default: lcState_r <= aea_pkg::AEA_LC_IDLE;
      endcase
    end
  end

  // Sign tracking for direction detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prevNeg_r <= 1'b0;
    end else if (sampleTick) begin
      prevNeg_r <= scaled[PW-1];
    end
  end

  // Status flags: set wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    logic [7:0] setThree;
    logic [7:0] setLow;
    logic dirEv;
    setThree = 8'h00;
    setLow = 8'h00;
    dirEv = 1'b0;
    if (!rst_n) begin
      irqStatusThree_r <= 8'h00;
      irqStatusLow_r <= 8'h00;
    end else begin
      setThree[`AEA_BIT_HALF] = evHalf;
      setThree[`AEA_BIT_OVF] = evOvf;
      setThree[`AEA_BIT_CYCDONE] = cycleEnd;
      dirEv = sampleTick && (accumulationConfig_r[`AEA_BIT_SIGNDIR]
              ? (prevNeg_r && !scaled[PW-1]) : (!prevNeg_r && scaled[PW-1]));
      setLow[`AEA_BIT_SIGN] = dirEv;
      setLow[`AEA_BIT_NOLOAD] = sampleTick && belowNl;
      if (regWr && regAddr == `AEA_OFS_IRQST3) begin
        irqStatusThree_r <= (irqStatusThree_r & regWdata[7:0]) | setThree;
      end else begin
        irqStatusThree_r <= irqStatusThree_r | setThree;
      end
      if (regWr && regAddr == `AEA_OFS_IRQST_LO) begin
        irqStatusLow_r <= (irqStatusLow_r & regWdata[7:0]) | setLow;
      end else begin
        irqStatusLow_r <= irqStatusLow_r | setLow;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqOut_r <= 1'b0;
    end else begin
      irqOut_r <= |(irqStatusThree_r & irqEnableThree_r & 8'h07);
    end
  end

  // Configuration registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      waveformSourceSelect_r <= 8'h00;
      accumulationConfig_r <= 8'h00;
      noloadConfig_r <= 8'h00;
      irqEnableThree_r <= 8'h00;
      energyDivider_r <= 8'h00;
      halfCycleCount_r <= 16'hffff;
      powerGain_r <= 12'h000;
    end else if (regWr) begin
      case (regAddr)
        `AEA_OFS_WAVSEL: waveformSourceSelect_r <= regWdata[7:0];
        `AEA_OFS_ACCCFG: accumulationConfig_r <= regWdata[7:0];
        `AEA_OFS_NLCFG: noloadConfig_r <= regWdata[7:0];
        `AEA_OFS_IRQEN3: irqEnableThree_r <= regWdata[7:0];
        `AEA_OFS_DIV: energyDivider_r <= regWdata[7:0];
        `AEA_OFS_HCYC: halfCycleCount_r <= regWdata[15:0];
        `AEA_OFS_GAIN: powerGain_r <= regWdata[11:0];
        default: ;
      endcase
    end
  end

  // Read data; unmapped reads return zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata_r <= 24'h000000;
    end else if (regRd) begin
      case (regAddr)
        `AEA_OFS_WAVSEL: regRdata_r <= {16'h0000, waveformSourceSelect_r};
        `AEA_OFS_ACCCFG: regRdata_r <= {16'h0000, accumulationConfig_r};
        `AEA_OFS_NLCFG: regRdata_r <= {16'h0000, noloadConfig_r};
        `AEA_OFS_IRQEN3: regRdata_r <= {16'h0000, irqEnableThree_r};
        `AEA_OFS_IRQST3: regRdata_r <= {16'h0000, irqStatusThree_r};
        `AEA_OFS_IRQST_LO: regRdata_r <= {16'h0000, irqStatusLow_r};
        `AEA_OFS_ENERGY: regRdata_r <= topOld;
        `AEA_OFS_ENRC: regRdata_r <= topOld;
        `AEA_OFS_DIV: regRdata_r <= {16'h0000, energyDivider_r};
        `AEA_OFS_HCYC: regRdata_r <= {8'h00, halfCycleCount_r};
        `AEA_OFS_LENERGY: regRdata_r <= lineCycleEnergy_r;
        `AEA_OFS_GAIN: regRdata_r <= {12'h000, powerGain_r};
        default: regRdata_r <= 24'h000000;
      endcase
    end
  end

  // Pulse output: carry out of a rate accumulator starts a fixed low pulse
  always_ff @(posedge clk or negedge rst_n) begin
    logic [PULSE_BIT:0] sumP;
    sumP = '0;
    if (!rst_n) begin
      pulseAcc_r <= '0;
      pulseLow_r <= 8'h00;
      energyPulseOut_n_r <= 1'b1;
    end else begin
      if (sampleTick) begin
        sumP = {1'b0, pulseAcc_r[PULSE_BIT-1:0]} + (PULSE_BIT+1)'(addend[PW-1] ? PW'(-addend) : addend);
        pulseAcc_r <= sumP;
      end
      if (sampleTick && sumP[PULSE_BIT]) begin
        pulseLow_r <= `AEA_PULSE_LOW;
      end else if (pulseLow_r != 8'h00) begin
        pulseLow_r <= pulseLow_r - 8'h01;
      end
      energyPulseOut_n_r <= (pulseLow_r == 8'h00);
    end
  end

  // Waveform samples: 25.6 kSPS base, selected divide by 1,2,4,8
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wavCnt_r <= 10'h000;
      wavValid_r <= 1'b0;
      wavData_r <= '0;
    end else begin
      wavCnt_r <= wavCnt_r + 10'h001;
      wavValid_r <= 1'b0;
      if (irqEnableThree_r[`AEA_BIT_WAVEFORM_SAMPLE_ENABLE] && waveformSourceSelect_r[4:2] == 3'h0 &&
          (wavCnt_r & ({10'h3ff} >> (2'h3 - waveformSourceSelect_r[6:5]))) == 10'h000) begin
        wavValid_r <= 1'b1;
        wavData_r <= scaled;
      end
    end
  end
endmodule : aea_active_energy

/* test/aea_active_energy_asserts.sv */
// Port checker for the active energy accumulator
`timescale 1ns/100ps
`include "aea_params.svh"
module aea_active_energy_asserts #(
  parameter int PW = 24
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Inputs
  input wire logic signed [PW-1:0] powerIn,
  input wire logic voltSign,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regAddr,
  input wire logic [23:0] regWdata,
  // Outputs
  input wire logic [23:0] regRdata_r,
  input wire logic energyPulseOut_n_r,
  input wire logic irqOut_r,
  input wire logic wavValid_r,
  input wire logic signed [PW-1:0] wavData_r
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic [4:0] lowCnt_r;
  // Saturates so a stuck-low pulse cannot wrap back into range
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lowCnt_r <= 5'h00;
    end else if (energyPulseOut_n_r) begin
      lowCnt_r <= 5'h00;
    end else if (lowCnt_r != 5'h1f) begin
      lowCnt_r <= lowCnt_r + 5'h01;
    end
  end
  sequence sWavQuiet;
    !wavValid_r [*8];
  endsequence
  AST_PULSE_WIDTH: assert property ($rose(energyPulseOut_n_r) |-> lowCnt_r == 5'h10)
    else $error("Pulse low time is not 16 clocks");
  AST_PULSE_MAX: assert property (lowCnt_r <= 5'h10)
    else $error("Pulse held low too long");
  AST_WAV_GAP: assert property (wavValid_r |=> sWavQuiet)
    else $error("Waveform samples too close");
  AST_RD_HOLD: assert property (!$past(regRd) |-> $stable(regRdata_r))
    else $error("Read data moved without a read");
  AST_IRQ_DROP: assert property ($fell(irqOut_r) |-> $past(regWr, 2) || $past(regWr, 3))
    else $error("Interrupt dropped without a write");
  AST_HCYC_W: assert property (regRd && regAddr == `AEA_OFS_HCYC |=> regRdata_r[23:16] == 8'h00)
    else $error("Half cycle count wider than 16 bits");
  AST_DIV_W: assert property (regRd && regAddr == `AEA_OFS_DIV |=> regRdata_r[23:8] == 16'h0000)
    else $error("Divider wider than 8 bits");
  AST_STAT_W: assert property (regRd && regAddr == `AEA_OFS_IRQST3 |=> regRdata_r[23:8] == 16'h0000)
    else $error("Status wider than 8 bits");
endmodule : aea_active_energy_asserts
bind aea_active_energy aea_active_energy_asserts #(.PW(PW)) aea_active_energy_asserts_inst (
  .clk(clk), .rst_n(rst_n), .powerIn(powerIn), .voltSign(voltSign), .regWr(regWr),
  .regRd(regRd), .regAddr(regAddr), .regWdata(regWdata), .regRdata_r(regRdata_r),
  .energyPulseOut_n_r(energyPulseOut_n_r), .irqOut_r(irqOut_r), .wavValid_r(wavValid_r),
  .wavData_r(wavData_r));

/* test/aea_core_model.sv */
// Core-side register access model
`timescale 1ns/100ps
module aea_core_model (
  // Clock
  input wire logic clk,
  // Register port
  output logic regWr,
  output logic regRd,
  output logic [7:0] regAddr,
  output logic [23:0] regWdata,
  input wire logic [23:0] regRdata_r
);
  initial begin
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWdata = 24'h000000;
  end
  // Writing the count register also restarts line accumulation
  task automatic writeReg(input logic [7:0] a, input logic [23:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
    regWdata <= ~d;
  endtask : writeReg
  task automatic readReg(input logic [7:0] a, output logic [23:0] q);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    q = regRdata_r;
  endtask : readReg
endmodule : aea_core_model

/* test/test_aea_active_energy.sv */
// Self-checking bench for the active energy accumulator
`timescale 1ns/100ps
`include "aea_params.svh"
module test_aea_active_energy;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic signed [23:0] powerIn = 24'h000000;
  logic voltSign = 1'b0;
  logic regWr, regRd, pulseOut_n, irqOut, wavValid;
  logic [7:0] regAddr;
  logic [23:0] regWdata, regRdata, rdVal;
  logic [23:0] pulses = 24'h000000;
  logic signed [23:0] wavData;
  int badCount = 0;
  int checks = 0;
  aea_active_energy aea_active_energy_inst (.clk(clk), .rst_n(rst_n), .powerIn(powerIn),
    .voltSign(voltSign), .regWr(regWr), .regRd(regRd), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata_r(regRdata), .energyPulseOut_n_r(pulseOut_n),
    .irqOut_r(irqOut), .wavValid_r(wavValid), .wavData_r(wavData));
  aea_core_model aea_core_model_inst (.clk(clk), .regWr(regWr), .regRd(regRd),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata_r(regRdata));
  initial begin
    forever #12.5 clk = ~clk;
  end
  always @(negedge pulseOut_n) pulses = pulses + 24'h1;
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      badCount++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Sample phase and leftover low bits allow one count of slack
  task automatic near(input logic [23:0] seen, input logic [23:0] exp);
    logic [23:0] d;
    d = seen - exp + 24'h1;
    check({23'h0, d <= 24'h2}, 24'h1);
  endtask : near
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    aea_core_model_inst.writeReg(a, d);
  endtask : wr
  task automatic runPower(input logic [23:0] p);
    @(posedge clk);
    powerIn <= p;
    repeat (400) @(posedge clk);
    powerIn <= 24'h0;
    repeat (20) @(posedge clk);
  endtask : runPower
  task automatic cycleRun(output logic [23:0] n);
    n = 24'h0;
    for (int k = 0; k < 800 && irqOut !== 1'b1; k++) begin
      @(posedge clk);
      if (k % 100 == 99) begin
        voltSign <= ~voltSign;
        n = n + 24'h1;
      end
    end
    powerIn <= 24'h0;
    check({23'h0, irqOut}, 24'h1);
  endtask : cycleRun
  task automatic test_reset_values;
    aea_core_model_inst.readReg(`AEA_OFS_ACCCFG, rdVal);
    check(rdVal, 24'h0);
    aea_core_model_inst.readReg(`AEA_OFS_HCYC, rdVal);
    check(rdVal, 24'h00ffff);
    aea_core_model_inst.readReg(8'h77, rdVal);
    check(rdVal, 24'h0);
  endtask : test_reset_values
  task automatic test_modes;
    logic [23:0] cfg [6] = '{24'h0, 24'h0, 24'h1, 24'h3, 24'h2, 24'h0};
    logic [23:0] dv [6] = '{24'h0, 24'h0, 24'h0, 24'h0, 24'h0, 24'h2};
    logic [23:0] pw [6] = '{24'h400000, 24'hc00000, 24'hc00000, 24'hc00000, 24'hc00000,
      24'h400000};
    logic [23:0] ex [6] = '{24'ha, 24'hfffff6, 24'h0, 24'h0, 24'ha, 24'h5};
    wr(`AEA_OFS_NLCFG, 24'h0);
    for (int i = 0; i < 6; i++) begin
      wr(`AEA_OFS_ACCCFG, cfg[i]);
      wr(`AEA_OFS_DIV, dv[i]);
      aea_core_model_inst.readReg(`AEA_OFS_ENRC, rdVal);
      pulses = 24'h0;
      runPower(pw[i]);
      aea_core_model_inst.readReg(`AEA_OFS_ENRC, rdVal);
      if (ex[i] == 24'h0) begin
        check(rdVal, 24'h0);
        check(pulses, 24'h0);
      end else begin
        near(rdVal, ex[i]);
      end
      aea_core_model_inst.readReg(`AEA_OFS_ENERGY, rdVal);
      check(rdVal, 24'h0);
    end
    wr(`AEA_OFS_ACCCFG, 24'h0);
    wr(`AEA_OFS_DIV, 24'h0);
  endtask : test_modes
  task automatic test_line_cycle;
    logic [23:0] n;
    wr(`AEA_OFS_IRQEN3, 24'h000004);
    wr(`AEA_OFS_HCYC, 24'h000002);
    @(posedge clk);
    powerIn <= 24'h400000;
    cycleRun(n);
    check(n, 24'h3);
    aea_core_model_inst.readReg(`AEA_OFS_IRQST3, rdVal);
    check({23'h0, rdVal[`AEA_BIT_CYCDONE]}, 24'h1);
    aea_core_model_inst.readReg(`AEA_OFS_LENERGY, rdVal);
    near(rdVal, 24'h5);
    wr(`AEA_OFS_IRQST3, 24'h0);
    repeat (4) @(posedge clk);
    check({23'h0, irqOut}, 24'h0);
    cycleRun(n);
    check(n, 24'h2);
    aea_core_model_inst.readReg(`AEA_OFS_LENERGY, rdVal);
    near(rdVal, 24'h0);
    wr(`AEA_OFS_IRQST3, 24'h0);
  endtask : test_line_cycle
  task automatic waitWav;
    int k;
    @(negedge clk);
    for (k = 0; k < 1100 && wavValid !== 1'b1; k++) @(negedge clk);
    check({23'h0, wavValid}, 24'h1);
  endtask : waitWav
  task automatic test_waveform;
    logic [23:0] gn [2] = '{24'h000800, 24'h0};
    logic [23:0] ex [2] = '{24'h200000, 24'h400000};
    wr(`AEA_OFS_WAVSEL, 24'h0);
    wr(`AEA_OFS_IRQEN3, 24'h000020);
    @(posedge clk);
    powerIn <= 24'h400000;
    for (int i = 0; i < 2; i++) begin
      wr(`AEA_OFS_GAIN, gn[i]);
      waitWav;
      waitWav;
      check(wavData, ex[i]);
    end
  endtask : test_waveform
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", checks, badCount);
    if (badCount == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up
  initial begin
    #1000000;
    badCount++;
    wrap_up;
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    test_reset_values;
    test_modes;
    test_line_cycle;
    test_waveform;
    wrap_up;
  end
endmodule : test_aea_active_energy
